// file: rtl/hsr_regs.sv
// Haptic driver status, identity and configuration register bank.
// Assumes an AHB-Lite master on hclk and event inputs synchronous to hclk.
//
// Functional notes
// RULE_01: Identity register read-only, part and revision nibbles
// RULE_02: Diagnostics actuator fault sets flag bit 7
// RULE_03: Calibration failure sets bit 7, sticky until read
// RULE_04: Impedance mode reports via readout, not bit 7
// RULE_05: Memory format fault sets sticky bit 4
// RULE_06: Sequencer, diagnostics or calibration done sets flag
// RULE_07: Supply below threshold latches sticky droop flag
// RULE_08: Over-temperature bit 1, overcurrent bit 0, sticky
// RULE_09: Clear-on-read atomic; simultaneous event stays set
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module hsr_regs #(
    parameter logic [3:0] PART_CODE = 4'h5, // Arbitrary value
    parameter logic [3:0] REV_CODE = 4'h9, // Arbitrary value
    parameter int MEM_AW = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire hsr_pkg::hsr_mode_type op_mode,
    input wire logic check_fail_event,
    input wire logic impedance_valid,
    input wire logic [7:0] impedance_value,
    input wire logic format_fault_event,
    input wire logic seq_done,
    input wire logic diag_done,
    input wire logic cal_done,
    input wire logic [2:0] supply_code,
    input wire logic over_temp,
    input wire logic overcurrent,
    output logic [hsr_pkg::CFG_COUNT*8-1:0] cfg_values,
    output logic [15:0] mem_pointer,
    output logic [2:0] supply_droop_threshold,
    output logic irq
);

    // ==========================================================
    // Bus data phase tracking
    logic dp_valid, dp_write, dp_upper_ok, dp_mem_ready, dp_mem_rd;
    logic [7:0] dp_index, rd8;
    logic accept, done, wr_done, rd_done, sel_flags, sel_data, status_read;

    assign accept = hsel && hready && (htrans == hsr_pkg::HTRANS_NONSEQ)
        && (hsize == hsr_pkg::HSIZE_WORD);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_upper_ok <= 1'b0;
            dp_index <= 8'h00;
        end else if (hreadyout) begin
            dp_valid <= accept;
            dp_write <= hwrite;
            dp_upper_ok <= (haddr[31:10] == '0) && (haddr[1:0] == '0);
            dp_index <= haddr[9:2];
        end
    end

    assign sel_flags = dp_upper_ok && (dp_index == hsr_pkg::IDX_EVENT_FLAGS);
    assign sel_data = dp_upper_ok && (dp_index == hsr_pkg::IDX_MEM_DATA_PORT);
    assign dp_mem_rd = dp_valid && !dp_write && sel_data;

    // Memory data read takes one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_mem_ready <= 1'b0;
        end else begin
            dp_mem_ready <= dp_mem_rd && !dp_mem_ready;
        end
    end

    assign hreadyout = !(dp_mem_rd && !dp_mem_ready);
    assign hresp = 1'b0;
    assign done = dp_valid && hreadyout;
    assign wr_done = done && dp_write;
    assign rd_done = done && !dp_write;

    // ==========================================================
    // Event flags
    logic [7:0] events, sticky_q, flags, mask, impedance;
    logic [1:0] reserved_q;

    always_comb begin
        events = 8'h00;
        events[hsr_pkg::BIT_CHECK_FAIL] = check_fail_event
            && (op_mode != hsr_pkg::HSR_MODE_IMPEDANCE); // RULE_02 RULE_03 RULE_04
        events[hsr_pkg::BIT_FORMAT_FAULT] = format_fault_event; // RULE_05
        events[hsr_pkg::BIT_PROCESS_DONE] = seq_done || diag_done
            || cal_done; // RULE_06
        events[hsr_pkg::BIT_SUPPLY_DROOP] =
            supply_code < supply_droop_threshold; // RULE_07
        events[hsr_pkg::BIT_OVER_TEMP] = over_temp; // RULE_08
        events[hsr_pkg::BIT_OVERCURRENT] = overcurrent; // RULE_08
    end

    assign status_read = rd_done && sel_flags;

    hsr_sticky_bits #(
        .W(8)
    ) u_flags (
        .clk(hclk),
        .rst_n(hresetn),
        .set(events),
        .clr({8{status_read}}), // RULE_09
        .q(sticky_q)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reserved_q <= hsr_pkg::RESERVED_RESET;
        end else if (wr_done && sel_flags) begin
            reserved_q <= hwdata[hsr_pkg::BIT_RESERVED_HI:
                hsr_pkg::BIT_RESERVED_LO];
        end
    end

    always_comb begin
        flags = sticky_q;
        flags[hsr_pkg::BIT_RESERVED_HI:hsr_pkg::BIT_RESERVED_LO] = reserved_q;
    end

    // ==========================================================
    // Mask and interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask <= hsr_pkg::MASK_RESET;
        end else if (wr_done && dp_upper_ok
                && dp_index == hsr_pkg::IDX_EVENT_MASK) begin
            mask <= hwdata[7:0];
        end
    end

    assign irq = |(sticky_q & mask);

    // ==========================================================
    // Impedance readout and droop threshold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            impedance <= hsr_pkg::IMPEDANCE_RESET;
        end else if (impedance_valid
                && op_mode == hsr_pkg::HSR_MODE_IMPEDANCE) begin
            impedance <= impedance_value; // RULE_04
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            supply_droop_threshold <= hsr_pkg::THRESHOLD_RESET;
        end else if (wr_done && dp_upper_ok
                && dp_index == hsr_pkg::IDX_DROOP_THRESHOLD) begin
            supply_droop_threshold <= hwdata[hsr_pkg::THRESHOLD_W-1:0];
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < hsr_pkg::CFG_COUNT; i++) begin
                cfg_values[i*8 +: 8] <= hsr_pkg::CFG_RESET[i];
            end
        end else begin
            for (int i = 0; i < hsr_pkg::CFG_COUNT; i++) begin
                if (wr_done && dp_upper_ok
                        && dp_index == hsr_pkg::CFG_INDEX[i]) begin
                    cfg_values[i*8 +: 8] <= hwdata[7:0];
                end
            end
        end
    end

    // ==========================================================
    // Memory pointer and data port
    hsr_mem_if #(.AW(MEM_AW)) mem_bus ();

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_pointer <= hsr_pkg::POINTER_RESET;
        end else if (done && sel_data) begin
            mem_pointer <= mem_pointer + 16'h0001;
        end else if (wr_done && dp_upper_ok
                && dp_index == hsr_pkg::IDX_MEM_POINTER_HIGH) begin
            mem_pointer[15:8] <= hwdata[7:0];
        end else if (wr_done && dp_upper_ok
                && dp_index == hsr_pkg::IDX_MEM_POINTER_LOW) begin
            mem_pointer[7:0] <= hwdata[7:0];
        end
    end

    assign mem_bus.we = wr_done && sel_data;
    assign mem_bus.re = dp_mem_rd && !dp_mem_ready;
    assign mem_bus.addr = mem_pointer[MEM_AW-1:0];
    assign mem_bus.wdata = hwdata[7:0];

    hsr_wave_mem #(
        .AW(MEM_AW)
    ) u_mem (
        .hclk(hclk),
        .hresetn(hresetn),
        .bus(mem_bus)
    );

    // ==========================================================
    // Read data
    always_comb begin
        rd8 = 8'h00;
        if (dp_upper_ok) begin
            unique case (dp_index)
                hsr_pkg::IDX_PART_IDENTITY: rd8 = {PART_CODE, REV_CODE}; // RULE_01
                hsr_pkg::IDX_EVENT_FLAGS: rd8 = flags;
                hsr_pkg::IDX_EVENT_MASK: rd8 = mask;
                hsr_pkg::IDX_IMPEDANCE: rd8 = impedance;
                hsr_pkg::IDX_DROOP_THRESHOLD:
                    rd8 = {5'h00, supply_droop_threshold};
                hsr_pkg::IDX_MEM_POINTER_HIGH: rd8 = mem_pointer[15:8];
                hsr_pkg::IDX_MEM_POINTER_LOW: rd8 = mem_pointer[7:0];
                hsr_pkg::IDX_MEM_DATA_PORT: rd8 = mem_bus.rdata;
                default: begin
                    for (int i = 0; i < hsr_pkg::CFG_COUNT; i++) begin
                        if (dp_index == hsr_pkg::CFG_INDEX[i]) begin
                            rd8 = cfg_values[i*8 +: 8];
                        end
                    end
                end
            endcase
        end
    end

    assign hrdata = {24'h00_0000, rd8};

    // ==========================================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_status_read;
        status_read;
    endsequence

    sequence s_quiet;
        events == 8'h00;
    endsequence

    property p_identity;
        rd_done && dp_upper_ok && dp_index == hsr_pkg::IDX_PART_IDENTITY
            |-> hrdata[7:0] == {PART_CODE, REV_CODE};
    endproperty
    a_identity: assert property (p_identity) // RULE_01
        else $error("identity read value wrong");

    property p_check_fail;
        check_fail_event && op_mode == hsr_pkg::HSR_MODE_DIAG
            |=> sticky_q[hsr_pkg::BIT_CHECK_FAIL];
    endproperty
    a_check_fail: assert property (p_check_fail) // RULE_02
        else $error("diagnostics fault not flagged");

    property p_cal_hold;
        sticky_q[hsr_pkg::BIT_CHECK_FAIL] && !status_read
            |=> sticky_q[hsr_pkg::BIT_CHECK_FAIL];
    endproperty
    a_cal_hold: assert property (p_cal_hold) // RULE_03
        else $error("fail flag dropped without a read");

    property p_impedance;
        impedance_valid && op_mode == hsr_pkg::HSR_MODE_IMPEDANCE
            && !sticky_q[hsr_pkg::BIT_CHECK_FAIL]
            |=> impedance == $past(impedance_value)
            && !sticky_q[hsr_pkg::BIT_CHECK_FAIL];
    endproperty
    a_impedance: assert property (p_impedance) // RULE_04
        else $error("impedance result path wrong");

    property p_format;
        format_fault_event |=> sticky_q[hsr_pkg::BIT_FORMAT_FAULT]
            ##1 (sticky_q[hsr_pkg::BIT_FORMAT_FAULT] || $past(status_read));
    endproperty
    a_format: assert property (p_format) // RULE_05
        else $error("format fault not held");

    property p_done;
        (seq_done || diag_done || cal_done)
            |=> sticky_q[hsr_pkg::BIT_PROCESS_DONE];
    endproperty
    a_done: assert property (p_done) // RULE_06
        else $error("done flag not set");

    property p_done_clear;
        s_status_read ##0 s_quiet |=> !sticky_q[hsr_pkg::BIT_PROCESS_DONE];
    endproperty
    a_done_clear: assert property (p_done_clear) // RULE_06
        else $error("done flag not cleared by read");

    property p_droop;
        supply_code < supply_droop_threshold
            |=> sticky_q[hsr_pkg::BIT_SUPPLY_DROOP];
    endproperty
    a_droop: assert property (p_droop) // RULE_07
        else $error("supply droop not latched");

    property p_temp_oc;
        over_temp || overcurrent |=>
            (sticky_q[hsr_pkg::BIT_OVER_TEMP] || !$past(over_temp))
            && (sticky_q[hsr_pkg::BIT_OVERCURRENT] || !$past(overcurrent));
    endproperty
    a_temp_oc: assert property (p_temp_oc) // RULE_08
        else $error("thermal or overcurrent flag missing");

    property p_read_clear;
        s_status_read |=> sticky_q == $past(events);
    endproperty
    a_read_clear: assert property (p_read_clear) // RULE_09
        else $error("clear on read lost an event");

    property p_irq;
        s_status_read ##0 s_quiet |=> !irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without unmasked flag");

endmodule // hsr_regs
`default_nettype wire

// file: rtl/hsr_pkg.sv
// Shared constants and types of the haptic status and identity registers.
// Assumes an AHB-Lite master with 32-bit data and word-aligned registers.
package hsr_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_PART_IDENTITY = 8'h00;
    localparam logic [7:0] IDX_EVENT_FLAGS = 8'h01;
    localparam logic [7:0] IDX_EVENT_MASK = 8'h02;
    localparam logic [7:0] IDX_IMPEDANCE = 8'h03;
    localparam logic [7:0] IDX_DROOP_THRESHOLD = 8'h09;
    localparam logic [7:0] IDX_MEM_POINTER_HIGH = 8'hfd;
    localparam logic [7:0] IDX_MEM_POINTER_LOW = 8'hfe;
    localparam logic [7:0] IDX_MEM_DATA_PORT = 8'hff;

    // ==========================================================
    // Configuration registers, plain read/write
    localparam int CFG_COUNT = 11;
    localparam logic [7:0] CFG_INDEX [CFG_COUNT] = '{
        8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a,
        8'h2c, 8'h2e, 8'h2f, 8'h30, 8'h31};
    localparam logic [7:0] CFG_RESET [CFG_COUNT] = '{
        8'h80, 8'h00, 8'h10, 8'h11, 8'h0c, 8'h02,
        8'h00, 8'h00, 8'hc6, 8'h00, 8'h00};

    // ==========================================================
    // Event flag bit positions
    localparam int BIT_CHECK_FAIL = 7;
    localparam int BIT_RESERVED_HI = 6;
    localparam int BIT_RESERVED_LO = 5;
    localparam int BIT_FORMAT_FAULT = 4;
    localparam int BIT_PROCESS_DONE = 3;
    localparam int BIT_SUPPLY_DROOP = 2;
    localparam int BIT_OVER_TEMP = 1;
    localparam int BIT_OVERCURRENT = 0;

    // ==========================================================
    // Reset values and widths
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [1:0] RESERVED_RESET = 2'h0;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] IMPEDANCE_RESET = 8'h00;
    localparam int THRESHOLD_W = 3;
    localparam logic [2:0] THRESHOLD_RESET = 3'h0;
    localparam logic [15:0] POINTER_RESET = 16'h0000;

    // ==========================================================
    // Bus codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        HSR_MODE_DIAG,
        HSR_MODE_IMPEDANCE,
        HSR_MODE_CALIBRATE
    } hsr_mode_type;

endpackage

// file: rtl/hsr_mem_if.sv
// Port between the register bank and the waveform memory.
// Assumes both ends run on the one bus clock.
`timescale 1ns/1ns
`default_nettype none
interface hsr_mem_if #(parameter int AW = 8);
    logic we;
    logic re;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output re, output addr, output wdata,
                  input rdata);
    modport store (input we, input re, input addr, input wdata,
                   output rdata);
endinterface
`default_nettype wire

// file: rtl/hsr_sticky_bits.sv
// Vector of sticky flags with set-over-clear priority.
// Assumes set and clear pulses synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module hsr_sticky_bits #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);

    // ==========================================================
    // Flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= (q & ~clr) | set; // RULE_09
        end
    end

endmodule // hsr_sticky_bits
`default_nettype wire

// file: rtl/hsr_wave_mem.sv
// Waveform memory, byte wide, registered read data.
// Assumes one access per cycle from the register bank.
`timescale 1ns/1ns
`default_nettype none
module hsr_wave_mem #(
    parameter int AW = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    hsr_mem_if.store bus
);

    logic [7:0] store [2**AW];

    // ==========================================================
    // Write port
    always_ff @(posedge hclk) begin
        if (bus.we) begin
            store[bus.addr] <= bus.wdata;
        end
    end

    // ==========================================================
    // Registered read port
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus.rdata <= 8'h00;
        end else if (bus.re) begin
            bus.rdata <= store[bus.addr];
        end
    end

endmodule // hsr_wave_mem
`default_nettype wire

// file: verification/hsr_host_model.sv
// Host-side master model issuing single AHB-Lite word transfers.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ns
`default_nettype none
module hsr_host_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0000_0000;
    end

    // ==========================================================
    // One transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= hsr_pkg::HTRANS_NONSEQ;
        hsize <= hsr_pkg::HSIZE_WORD;
        do @(negedge hclk); while (hready !== 1'b1);
        @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(negedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
        hwdata <= ~wd;
    endtask
endmodule // hsr_host_model
`default_nettype wire

// file: verification/haptic_status_id_registers_tb.sv
// Self-checking bench for the haptic status and identity registers.
// Assumes the host model drives the bus and hready follows hreadyout.
`timescale 1ns/1ns
`default_nettype none
module haptic_status_id_registers_tb;
    localparam logic [3:0] PART = 4'h3; // Arbitrary value
    localparam logic [3:0] SILICON_STEP_FIELD = 4'ha; // Arbitrary value
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    hsr_pkg::hsr_mode_type op_mode = hsr_pkg::HSR_MODE_DIAG;
    logic check_fail_event = 1'b0;
    logic impedance_valid = 1'b0;
    logic [7:0] impedance_value = 8'h00;
    logic format_fault_event = 1'b0;
    logic seq_done = 1'b0;
    logic diag_done = 1'b0;
    logic cal_done = 1'b0;
    logic [2:0] supply_code = 3'h7;
    logic over_temp = 1'b0;
    logic overcurrent = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, irq;
    logic [1:0] htrans;
    logic [2:0] hsize, supply_droop_threshold;
    logic [31:0] haddr, hwdata, hrdata;
    logic [hsr_pkg::CFG_COUNT*8-1:0] cfg_values;
    logic [15:0] mem_pointer;
    int err_count = 0;
    int n_checks = 0;

    always #10 hclk = ~hclk;

    hsr_regs #(.PART_CODE(PART), .REV_CODE(SILICON_STEP_FIELD), .MEM_AW(8)) hsr_regs_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .op_mode(op_mode),
        .check_fail_event(check_fail_event),
        .impedance_valid(impedance_valid),
        .impedance_value(impedance_value),
        .format_fault_event(format_fault_event), .seq_done(seq_done),
        .diag_done(diag_done), .cal_done(cal_done),
        .supply_code(supply_code), .over_temp(over_temp),
        .overcurrent(overcurrent), .cfg_values(cfg_values),
        .mem_pointer(mem_pointer),
        .supply_droop_threshold(supply_droop_threshold), .irq(irq));

    hsr_host_model hsr_host_model_i (
        .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    // ==========================================================
    // Helpers
    task automatic complete_run();
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] ad(input logic [7:0] idx);
        return {22'h0, idx, 2'h0};
    endfunction

    function automatic logic [31:0] exp_flag(input logic [9:0] v);
        return {24'h0, v[7], 2'h0, v[4], |{v[9], v[8], v[3]}, 1'h0, v[1:0]};
    endfunction

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        hsr_host_model_i.xfer(1'b1, a, d, r);
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        hsr_host_model_i.xfer(1'b0, a, 32'h0000_0000, r);
        check(r, e);
    endtask

    task automatic irq_is(input logic [31:0] e);
        @(negedge hclk);
        check(32'(irq), e);
        @(posedge hclk);
    endtask

    task automatic ev(input logic [9:0] v);
        check_fail_event <= v[7];
        format_fault_event <= v[4];
        seq_done <= v[3];
        diag_done <= v[8];
        cal_done <= v[9];
        over_temp <= v[1];
        overcurrent <= v[0];
        @(posedge hclk);
        {check_fail_event, format_fault_event, seq_done} <= 3'h0;
        {diag_done, cal_done, over_temp, overcurrent} <= 4'h0;
        @(posedge hclk);
    endtask

    initial begin
        repeat (5000) @(posedge hclk);
        err_count++;
        complete_run();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] cfg [hsr_pkg::CFG_COUNT];
        logic [7:0] b [3];
        logic [31:0] v;
        logic [31:0] fl;
        v = $urandom(32'h750b);
        fl = ad(hsr_pkg::IDX_EVENT_FLAGS);
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(ad(hsr_pkg::IDX_PART_IDENTITY), {24'h0, PART, SILICON_STEP_FIELD});
        wr(ad(hsr_pkg::IDX_PART_IDENTITY), 32'h0000_00ff);
        rchk(ad(hsr_pkg::IDX_PART_IDENTITY), {24'h0, PART, SILICON_STEP_FIELD});
        rchk(32'h0000_0400, 32'h0000_0000);
        rchk(ad(8'h40), 32'h0000_0000);
        rchk(fl, 32'h0000_0000);
        rchk(ad(hsr_pkg::IDX_EVENT_MASK), 32'h0000_0000);
        check(32'(hresp), 32'h0000_0000);
        for (int k = 0; k < hsr_pkg::CFG_COUNT; k++) begin
            rchk(ad(hsr_pkg::CFG_INDEX[k]), {24'h0, hsr_pkg::CFG_RESET[k]});
            cfg[k] = 8'($urandom);
            wr(ad(hsr_pkg::CFG_INDEX[k]), {24'h0, cfg[k]});
        end
        for (int k = 0; k < hsr_pkg::CFG_COUNT; k++) begin
            rchk(ad(hsr_pkg::CFG_INDEX[k]), {24'h0, cfg[k]});
            check({24'h0, cfg_values[8*k+:8]}, {24'h0, cfg[k]});
        end
        for (int k = 0; k < 10; k++) begin
            if (!(k inside {2, 5, 6})) begin
                ev(10'h001 << k);
                rchk(fl, exp_flag(10'h001 << k));
                rchk(fl, 32'h0000_0000);
            end
        end
        wr(ad(hsr_pkg::IDX_DROOP_THRESHOLD), 32'h0000_0005);
        supply_code <= 3'h5;
        repeat (2) @(posedge hclk);
        rchk(fl, 32'h0000_0000);
        supply_code <= 3'h4;
        @(posedge hclk);
        supply_code <= 3'h7;
        repeat (4) @(posedge hclk);
        rchk(fl, 32'h0000_0004);
        rchk(fl, 32'h0000_0000);
        op_mode <= hsr_pkg::HSR_MODE_CALIBRATE;
        ev(10'h080);
        repeat (5) @(posedge hclk);
        rchk(fl, 32'h0000_0080);
        rchk(fl, 32'h0000_0000);
        op_mode <= hsr_pkg::HSR_MODE_IMPEDANCE;
        v = $urandom;
        impedance_value <= v[7:0];
        impedance_valid <= 1'b1;
        ev(10'h080);
        impedance_valid <= 1'b0;
        rchk(fl, 32'h0000_0000);
        rchk(ad(hsr_pkg::IDX_IMPEDANCE), {24'h0, v[7:0]});
        op_mode <= hsr_pkg::HSR_MODE_DIAG;
        wr(fl, 32'h0000_00ff);
        rchk(fl, 32'h0000_0060);
        wr(fl, 32'h0000_0000);
        wr(ad(hsr_pkg::IDX_EVENT_MASK), 32'h0000_0002);
        ev(10'h002);
        irq_is(32'h0000_0001);
        rchk(fl, 32'h0000_0002);
        irq_is(32'h0000_0000);
        ev(10'h001);
        irq_is(32'h0000_0000);
        rchk(fl, 32'h0000_0001);
        over_temp <= 1'b1;
        rchk(fl, 32'h0000_0002);
        over_temp <= 1'b0;
        irq_is(32'h0000_0001);
        rchk(fl, 32'h0000_0002);
        rchk(fl, 32'h0000_0000);
        wr(ad(hsr_pkg::IDX_MEM_POINTER_HIGH), 32'h0000_0000);
        wr(ad(hsr_pkg::IDX_MEM_POINTER_LOW), 32'h0000_0010);
        for (int k = 0; k < 3; k++) begin
            b[k] = 8'($urandom);
            wr(ad(hsr_pkg::IDX_MEM_DATA_PORT), {24'h0, b[k]});
        end
        @(negedge hclk);
        check({16'h0, mem_pointer}, 32'h0000_0013);
        check({29'h0, supply_droop_threshold}, 32'h0000_0005);
        @(posedge hclk);
        wr(ad(hsr_pkg::IDX_MEM_POINTER_LOW), 32'h0000_0010);
        for (int k = 0; k < 3; k++) begin
            rchk(ad(hsr_pkg::IDX_MEM_DATA_PORT), {24'h0, b[k]});
        end
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        for (int k = 0; k < hsr_pkg::CFG_COUNT; k++) begin
            check({24'h0, cfg_values[8*k+:8]}, {24'h0, hsr_pkg::CFG_RESET[k]});
        end
        check({29'h0, supply_droop_threshold}, 32'h0000_0000);
        check(32'(hreadyout), 32'h0000_0001);
        complete_run();
    end
endmodule // haptic_status_id_registers_tb
`default_nettype wire
